/* design/lcdd_pkg.sv */
// Shared constants and carrier types for the LCD display RAM drive block
`default_nettype none
package lcdd_pkg;
  localparam int          NUM_SEG     = 44;
  localparam int          NUM_COM     = 4;
  localparam int          RAM_BYTES   = 22;
  localparam logic [4:0]  RAM_LAST    = 5'h15;
  // Register offsets on the plain register port
  localparam logic [7:0]  REG_RAM_TOP = 8'h15;
  localparam logic [7:0]  REG_MODE    = 8'h20;
  localparam logic [7:0]  REG_SYSCTL  = 8'h21;
  localparam logic [7:0]  REG_BLINK   = 8'h22;
  localparam logic [7:0]  REG_VADJ    = 8'h23;
  localparam logic [7:0]  REG_PTR     = 8'h24;
  localparam logic [7:0]  REG_DATA    = 8'h25;
  localparam logic [7:0]  REG_STATUS  = 8'h26;
  // Field positions
  localparam int          MODE_HALF   = 0;
  localparam int          MODE_FAST   = 1;
  localparam int          SYS_OSC     = 0;
  localparam int          SYS_BIAS    = 1;
  localparam int          SYS_DISP    = 2;
  localparam int          VADJ_EN     = 4;
  localparam int          VADJ_DET    = 5;
  // Reset values
  localparam logic [3:0]  VADJ_LVL_RST = 4'h0;
  localparam logic        VADJ_EN_RST  = 1'b1;
  localparam logic        VADJ_DET_RST = 1'b0;
  // Timing
  localparam int          REF_CLK_HZ      = 125_000_000;
  localparam int          SYS_OSC_HZ      = 32768;
  localparam int          SYS_DIV         = REF_CLK_HZ / SYS_OSC_HZ;
  localparam int          FRAME_HZ_SLOW   = 80;
  localparam int          FRAME_HZ_FAST   = 160;
  localparam logic [6:0]  SLOT_LAST_SLOW  = 7'(SYS_OSC_HZ / (FRAME_HZ_SLOW * NUM_COM) - 1);
  localparam logic [6:0]  SLOT_LAST_FAST  = 7'(SYS_OSC_HZ / (FRAME_HZ_FAST * NUM_COM) - 1);
  localparam int          BLINK_RATIO_1   = 16384;
  localparam int          BLINK_RATIO_2   = 32768;
  localparam int          BLINK_RATIO_3   = 65536;
  localparam int          BLINK_BIT_1     = $clog2(BLINK_RATIO_1) - 1;
  localparam int          BLINK_BIT_2     = $clog2(BLINK_RATIO_2) - 1;
  localparam int          BLINK_BIT_3     = $clog2(BLINK_RATIO_3) - 1;
  localparam int          HOST_WAIT_MS    = 1;
  // Drive level codes: supply rail, low tap, high tap, drive voltage
  localparam logic [1:0]  LVL_VSS  = 2'h0;
  localparam logic [1:0]  LVL_LOW  = 2'h1;
  localparam logic [1:0]  LVL_HIGH = 2'h2;
  localparam logic [1:0]  LVL_DRIVE_VOLTAGE_PIN = 2'h3;

  typedef struct packed {
    logic       half_bias;
    logic       fast_frame;
    logic       osc_en;
    logic       bias_en;
    logic       disp_en;
    logic [1:0] blink_mode;
  } lcdd_cfg_t;

  // Reset configuration: third bias, 80Hz, all off, no blink
  localparam lcdd_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0};

  typedef struct packed {
    logic [1:0] slot;
    logic       polarity;
    logic       blank;
    logic       slot_start;
  } lcdd_phase_t;
endpackage
`default_nettype wire

/* design/lcdd_timebase.sv */
// System oscillator divider, common slot sequencer, frame polarity and blink timer
`default_nettype none
module lcdd_timebase #(
  parameter int SYS_DIV = lcdd_pkg::SYS_DIV
) (
  input  wire logic               ref_clk_in,
  input  wire logic               sys_rst_in,
  input  wire lcdd_pkg::lcdd_cfg_t cfg_in,
  output var  lcdd_pkg::lcdd_phase_t phase_out
);
  localparam logic [11:0] DIV_LAST = 12'(SYS_DIV - 1);

  typedef struct packed {
    logic [11:0] div;
    logic [6:0]  tick;
    logic [1:0]  slot;
    logic        pol;
    logic [15:0] blink;
    logic        start;
  } lcdd_tb_state_t;

  lcdd_tb_state_t st_ff;
  lcdd_tb_state_t nxt_st;
  logic [6:0]     slot_last;

  // All timing runs off the oscillator tick; stopped oscillator clears it to zero
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.start = 1'b0;
    slot_last = cfg_in.fast_frame ? lcdd_pkg::SLOT_LAST_FAST : lcdd_pkg::SLOT_LAST_SLOW;
    if (!cfg_in.osc_en) begin
      nxt_st = '0;
    end else if (st_ff.div == DIV_LAST) begin
      nxt_st.div   = 12'h000;
      nxt_st.blink = st_ff.blink + 16'h0001;
      if (st_ff.tick >= slot_last) begin
        nxt_st.tick  = 7'h00;
        nxt_st.slot  = st_ff.slot + 2'h1;
        nxt_st.start = 1'b1;
        if (st_ff.slot == 2'h3) begin
          nxt_st.pol = ~st_ff.pol;
        end
      end else begin
        nxt_st.tick = st_ff.tick + 7'h01;
      end
    end else begin
      nxt_st.div = st_ff.div + 12'h001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Whole display blanks during the second half of each blink period
  always_comb begin
    phase_out.slot       = st_ff.slot;
    phase_out.polarity   = st_ff.pol;
    phase_out.slot_start = st_ff.start;
    case (cfg_in.blink_mode)
      2'h1:    phase_out.blank = st_ff.blink[lcdd_pkg::BLINK_BIT_1];
      2'h2:    phase_out.blank = st_ff.blink[lcdd_pkg::BLINK_BIT_2];
      2'h3:    phase_out.blank = st_ff.blink[lcdd_pkg::BLINK_BIT_3];
      default: phase_out.blank = 1'b0;
    endcase
  end

  default clocking tb_cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  pol_flip_a: assert property (st_ff.start && st_ff.slot == 2'h0 |-> st_ff.pol != $past(st_ff.pol))
    else $error("polarity did not flip at frame start");
  blink_off_a: assert property (cfg_in.blink_mode == 2'h0 |-> !phase_out.blank)
    else $error("blank raised with blinking off");
  // A slow slot caught mid-way by a switch to fast must end, never count on
  slot_bound_a: assert property (cfg_in.fast_frame && st_ff.tick > lcdd_pkg::SLOT_LAST_FAST
                                 |=> st_ff.tick <= $past(st_ff.tick))
    else $error("slot ran past the fast frame length");
  osc_stop_a: assert property (!cfg_in.osc_en |=> st_ff.div == 12'h000 && !st_ff.start)
    else $error("timing ran with oscillator stopped");
endmodule
`default_nettype wire

/* design/lcdd_level_drive.sv */
// Maps slot, polarity and latched column bits to common and segment drive levels
`default_nettype none
module lcdd_level_drive (
  input  wire logic        active_in,
  input  wire logic        half_bias_in,
  input  wire logic [1:0]  slot_in,
  input  wire logic        pol_in,
  input  wire logic [43:0] col_in,
  output logic      [7:0]  com_lvl_out,
  output logic      [87:0] seg_lvl_out
);
  // Selected common swings to a rail, the others sit on a tap
  function automatic logic [1:0] com_level(input logic sel, input logic pol);
    if (sel) return pol ? lcdd_pkg::LVL_VSS : lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN;
    return pol ? lcdd_pkg::LVL_HIGH : lcdd_pkg::LVL_LOW;
  endfunction

  // Off segments at half bias follow the selected common rail
  function automatic logic [1:0] seg_level(input logic on, input logic pol, input logic half);
    if (on) return pol ? lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN : lcdd_pkg::LVL_VSS;
    if (half) return pol ? lcdd_pkg::LVL_VSS : lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN;
    return pol ? lcdd_pkg::LVL_LOW : lcdd_pkg::LVL_HIGH;
  endfunction

  // Idle pins rest on the drive voltage until the display runs
  always_comb begin
    for (int c = 0; c < lcdd_pkg::NUM_COM; c++) begin
      com_lvl_out[2*c +: 2] = active_in ? com_level(slot_in == 2'(c), pol_in)
                                        : lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN;
    end
    for (int s = 0; s < lcdd_pkg::NUM_SEG; s++) begin
      seg_lvl_out[2*s +: 2] = active_in ? seg_level(col_in[s], pol_in, half_bias_in)
                                        : lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN;
    end
  end
endmodule
`default_nettype wire

/* design/lcdd_core.sv */
// Display RAM, register port, display latch and registered LCD pin drive
`default_nettype none
module lcdd_core #(
  parameter int SYS_DIV = lcdd_pkg::SYS_DIV
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  output logic      [7:0]  common_outputs_out,
  output logic      [87:0] segment_outputs_out,
  output logic             bias_centre_bypass_out,
  output logic             osc_run_out,
  output logic             bias_gen_on_out,
  output logic             vadj_enable_out,
  output logic             drive_voltage_pin_detect_out,
  output logic      [3:0]  vadj_level_out
);
  typedef struct packed {
    lcdd_pkg::lcdd_cfg_t cfg;
    logic [3:0]          vadj_lvl;
    logic                vadj_en;
    logic                vadj_det;
    logic [4:0]          ptr;
    logic [21:0][7:0]    ram;
    logic [43:0]         col;
    logic [1:0]          slot_l;
    logic                pol_l;
    logic [7:0]          rdata;
    logic [7:0]          com;
    logic [87:0]         seg;
    logic                bypass;
  } lcdd_core_state_t;

  lcdd_core_state_t      st_ff;
  lcdd_core_state_t      nxt_st;
  lcdd_pkg::lcdd_phase_t phase;
  logic                  active;
  logic [43:0]           col_now;
  logic [7:0]            com_lvl;
  logic [87:0]           seg_lvl;

  // One storage column: even segment from low nibble, odd from high nibble
  function automatic logic [43:0] col_of(input logic [21:0][7:0] ram, input logic [1:0] c);
    logic [43:0] col;
    col = '0;
    for (int k = 0; k < lcdd_pkg::RAM_BYTES; k++) begin
      col[2*k]     = ram[k][{1'b0, c}];
      col[2*k + 1] = ram[k][{1'b1, c}];
    end
    return col;
  endfunction

  // Register readback; unmapped offsets read as zero
  function automatic logic [7:0] read_value(input lcdd_core_state_t s,
                                            input lcdd_pkg::lcdd_phase_t ph,
                                            input logic act,
                                            input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (addr <= lcdd_pkg::REG_RAM_TOP) begin
      v = s.ram[addr[4:0]];
    end else begin
      case (addr)
        lcdd_pkg::REG_MODE: begin
          v[lcdd_pkg::MODE_HALF] = s.cfg.half_bias;
          v[lcdd_pkg::MODE_FAST] = s.cfg.fast_frame;
        end
        lcdd_pkg::REG_SYSCTL: begin
          v[lcdd_pkg::SYS_OSC]  = s.cfg.osc_en;
          v[lcdd_pkg::SYS_BIAS] = s.cfg.bias_en;
          v[lcdd_pkg::SYS_DISP] = s.cfg.disp_en;
        end
        lcdd_pkg::REG_BLINK:  v[1:0] = s.cfg.blink_mode;
        lcdd_pkg::REG_VADJ: begin
          v[3:0]                = s.vadj_lvl;
          v[lcdd_pkg::VADJ_EN]  = s.vadj_en;
          v[lcdd_pkg::VADJ_DET] = s.vadj_det;
        end
        lcdd_pkg::REG_PTR:    v[4:0] = s.ptr;
        lcdd_pkg::REG_DATA:   v = s.ram[s.ptr];
        lcdd_pkg::REG_STATUS: v = {3'h0, ph.blank, ph.polarity, ph.slot, act};
        default:              v = 8'h00;
      endcase
    end
    return v;
  endfunction

  lcdd_timebase #(
    .SYS_DIV (SYS_DIV)
  ) u_timebase (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .cfg_in     (st_ff.cfg),
    .phase_out  (phase)
  );

  lcdd_level_drive u_level (
    .active_in    (active),
    .half_bias_in (st_ff.cfg.half_bias),
    .slot_in      (st_ff.slot_l),
    .pol_in       (st_ff.pol_l),
    .col_in       (st_ff.col),
    .com_lvl_out  (com_lvl),
    .seg_lvl_out  (seg_lvl)
  );

  // Panel runs only with oscillator, bias generator and display all on
  assign active  = st_ff.cfg.osc_en & st_ff.cfg.bias_en & st_ff.cfg.disp_en;
  assign col_now = col_of(st_ff.ram, phase.slot);

  // Register writes, display latch and output staging
  always_comb begin
    nxt_st = st_ff;
    if (reg_wr_in) begin
      if (reg_addr_in <= lcdd_pkg::REG_RAM_TOP) begin
        nxt_st.ram[reg_addr_in[4:0]] = reg_wdata_in;
      end else begin
        case (reg_addr_in)
          lcdd_pkg::REG_MODE: begin
            nxt_st.cfg.half_bias  = reg_wdata_in[lcdd_pkg::MODE_HALF];
            nxt_st.cfg.fast_frame = reg_wdata_in[lcdd_pkg::MODE_FAST];
          end
          lcdd_pkg::REG_SYSCTL: begin
            nxt_st.cfg.osc_en  = reg_wdata_in[lcdd_pkg::SYS_OSC];
            nxt_st.cfg.bias_en = reg_wdata_in[lcdd_pkg::SYS_BIAS];
            nxt_st.cfg.disp_en = reg_wdata_in[lcdd_pkg::SYS_DISP];
          end
          lcdd_pkg::REG_BLINK: nxt_st.cfg.blink_mode = reg_wdata_in[1:0];
          lcdd_pkg::REG_VADJ: begin
            nxt_st.vadj_lvl = reg_wdata_in[3:0];
            nxt_st.vadj_en  = reg_wdata_in[lcdd_pkg::VADJ_EN];
            nxt_st.vadj_det = reg_wdata_in[lcdd_pkg::VADJ_DET];
          end
          lcdd_pkg::REG_PTR: begin
            // Pointers past the top address fold back to zero
            nxt_st.ptr = (reg_wdata_in[4:0] > lcdd_pkg::RAM_LAST) ? 5'h00 : reg_wdata_in[4:0];
          end
          lcdd_pkg::REG_DATA: begin
            // Bit seven of the byte lands on the odd segment's common 3
            nxt_st.ram[st_ff.ptr] = reg_wdata_in;
            nxt_st.ptr = (st_ff.ptr == lcdd_pkg::RAM_LAST) ? 5'h00 : st_ff.ptr + 5'h01;
          end
          default: nxt_st.ptr = st_ff.ptr;
        endcase
      end
    end
    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = reg_rd_in ? read_value(st_ff, phase, active, reg_addr_in) : 8'h00;
    // Latch reloads on slot edges and every cycle while inactive, so a byte write never splits a running slot
    if (phase.slot_start || !active) begin
      nxt_st.col    = phase.blank ? 44'h000_0000_0000 : col_now;
      nxt_st.slot_l = phase.slot;
      nxt_st.pol_l  = phase.polarity;
    end
    nxt_st.com    = com_lvl;
    nxt_st.seg    = seg_lvl;
    nxt_st.bypass = st_ff.cfg.half_bias & st_ff.cfg.bias_en;
  end

  // Reset defaults: third bias, 80Hz, all off, no blink, adjust on, detect off
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_ff          <= '0;
      st_ff.cfg      <= lcdd_pkg::CFG_RST;
      st_ff.vadj_lvl <= lcdd_pkg::VADJ_LVL_RST;
      st_ff.vadj_en  <= lcdd_pkg::VADJ_EN_RST;
      st_ff.vadj_det <= lcdd_pkg::VADJ_DET_RST;
      st_ff.com      <= {lcdd_pkg::NUM_COM{lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN}};
      st_ff.seg      <= {lcdd_pkg::NUM_SEG{lcdd_pkg::LVL_DRIVE_VOLTAGE_PIN}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every pin comes straight from the state register
  assign reg_rdata_out          = st_ff.rdata;
  assign common_outputs_out     = st_ff.com;
  assign segment_outputs_out    = st_ff.seg;
  assign bias_centre_bypass_out = st_ff.bypass;
  assign osc_run_out            = st_ff.cfg.osc_en;
  assign bias_gen_on_out        = st_ff.cfg.bias_en;
  assign vadj_enable_out        = st_ff.vadj_en;
  assign drive_voltage_pin_detect_out        = st_ff.vadj_det;
  assign vadj_level_out         = st_ff.vadj_lvl;

  // Checks on the display path and register port
  logic data_wr;
  assign data_wr = reg_wr_in && reg_addr_in == lcdd_pkg::REG_DATA;

  default clocking core_cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  reset_defaults_a: assert property (@(posedge ref_clk_in) disable iff (1'b0)
    $past(sys_rst_in) && !sys_rst_in
    |-> st_ff.cfg == lcdd_pkg::CFG_RST && vadj_enable_out && !drive_voltage_pin_detect_out
        && vadj_level_out == lcdd_pkg::VADJ_LVL_RST)
    else $error("configuration not at its reset defaults");
  com_idle_a: assert property (!active ##1 !active |-> common_outputs_out == 8'hFF)
    else $error("common left the idle level while display off");
  seg_idle_a: assert property (!active ##1 !active |-> &segment_outputs_out)
    else $error("segment left the idle level while display off");
  ptr_wrap_a: assert property (data_wr && st_ff.ptr == lcdd_pkg::RAM_LAST |=> st_ff.ptr == 5'h00)
    else $error("pointer did not wrap to zero");
  ptr_inc_a: assert property (data_wr && st_ff.ptr < lcdd_pkg::RAM_LAST
                              |=> st_ff.ptr == $past(st_ff.ptr) + 5'h01)
    else $error("pointer did not advance after a data byte");
  ram_write_a: assert property (data_wr |=> st_ff.ram[$past(st_ff.ptr)] == $past(reg_wdata_in))
    else $error("data byte not stored at the pointer");
  col_load_a: assert property (active && phase.slot_start && !phase.blank
                               |=> st_ff.col == $past(col_now))
    else $error("latch did not take the slot's column");
  latch_hold_a: assert property (active && $past(active) && !$past(phase.slot_start)
                                 |-> $stable(st_ff.col))
    else $error("display latch changed inside a slot");
  seg_on_a: assert property (active && st_ff.col[0] && !st_ff.pol_l
                             |=> segment_outputs_out[1:0] == lcdd_pkg::LVL_VSS)
    else $error("lit segment not driven against the common");
  com_select_a: assert property (active && st_ff.slot_l == 2'h2 && st_ff.pol_l
                                 |=> common_outputs_out[5:4] == lcdd_pkg::LVL_VSS)
    else $error("selected common not at its rail");
  bypass_a: assert property (st_ff.cfg.half_bias && st_ff.cfg.bias_en ##1 st_ff.cfg.bias_en
                             |-> bias_centre_bypass_out)
    else $error("centre divider element not bypassed at half bias");
  read_once_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data stood beyond its cycle");

  wrap_c:   cover property (data_wr && st_ff.ptr == lcdd_pkg::RAM_LAST);
  active_c: cover property (active && phase.slot_start && phase.slot == 2'h3);
  blink_c:  cover property (active && phase.blank && phase.slot_start);
  half_c:   cover property (active && st_ff.cfg.half_bias && phase.slot_start);
  fast_c:   cover property (active && st_ff.cfg.fast_frame && phase.slot_start);
endmodule
`default_nettype wire

/* dv/lcdd_host_model.sv */
// Host side model driving the plain register port
`default_nettype none
module lcdd_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] reg_rdata_in,
  output var  logic [7:0] reg_addr_out,
  output var  logic [7:0] reg_wdata_out,
  output var  logic       reg_wr_out,
  output var  logic       reg_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles quiet from time zero; the bench delays the first access past reset
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // One-cycle write strobe beside address and whole data byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
  endtask
  // Read data only stands in the cycle after the strobe, so sample it there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    #1 d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

/* dv/tb_lcdd_core.sv */
// Self-checking bench for the LCD display RAM drive core
`default_nettype none
module tb_lcdd_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  addr, wdata, rdata, com;
  logic        wr, rd, byp, osc, bias, ven, vdet;
  logic [87:0] seg;
  logic [3:0]  vlvl;
  logic [7:0]  ram [22];
  int          num_errors = 0;
  int          tests_run = 0;
  localparam int SYS_DIV_TB = 2;
  localparam int FAST_SLOT  = (lcdd_pkg::SYS_OSC_HZ / (lcdd_pkg::FRAME_HZ_FAST * lcdd_pkg::NUM_COM))
                              * SYS_DIV_TB;
  always #4 ref_clk_in = ~ref_clk_in;
  lcdd_host_model host (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
  // Short oscillator divide keeps a slot at 204 reference cycles and blink within reach
  lcdd_core #(.SYS_DIV(SYS_DIV_TB)) dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .common_outputs_out(com), .segment_outputs_out(seg),
    .bias_centre_bypass_out(byp), .osc_run_out(osc), .bias_gen_on_out(bias),
    .vadj_enable_out(ven), .drive_voltage_pin_detect_out(vdet), .vadj_level_out(vlvl));
  task automatic cmp(input string what, input logic [87:0] exp, input logic [87:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    cmp("read data", {80'h0, exp}, {80'h0, d});
  endtask
  // Expected commons: selected one at the outer rail, the rest at a tap
  function automatic logic [7:0] exp_com(input int slot, input logic pol);
    for (int c = 0; c < 4; c++) begin
      exp_com[2*c+:2] = (c == slot) ? (pol ? 2'h0 : 2'h3) : (pol ? 2'h2 : 2'h1);
    end
  endfunction
  // Expected segments from the bench's own copy of display storage
  function automatic logic [87:0] exp_seg(input int slot, input logic pol, input logic half);
    logic b;
    for (int s = 0; s < 44; s++) begin
      b = ram[s/2][(s%2)*4+slot];
      exp_seg[2*s+:2] = pol ? (b ? 2'h3 : (half ? 2'h0 : 2'h1)) : (b ? 2'h0 : (half ? 2'h3 : 2'h2));
    end
  endfunction
  // Wait a bounded time for a slot to appear, then judge both pin groups
  task automatic slot_cmp(input int slot, input logic pol, input logic half);
    int n;
    n = 0;
    while (com !== exp_com(slot, pol) && n < 600) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    cmp("commons", {80'h0, exp_com(slot, pol)}, {80'h0, com});
    cmp("segments", exp_seg(slot, pol, half), seg);
  endtask
  task automatic t_reset;
    cmp("commons idle", {80'h0, 8'hFF}, {80'h0, com});
    cmp("segments idle", {88{1'b1}}, seg);
    cmp("osc bias", 88'h0, {86'h0, osc, bias});
    cmp("adjust on", 88'h1, {87'h0, ven});
    cmp("detect off", 88'h0, {83'h0, vdet, vlvl});
    rd_cmp(lcdd_pkg::REG_MODE, 8'h00);
    rd_cmp(lcdd_pkg::REG_SYSCTL, 8'h00);
    rd_cmp(lcdd_pkg::REG_BLINK, 8'h00);
    rd_cmp(8'h30, 8'h00);
  endtask
  // Fill storage through the pointer, crossing the top address
  task automatic t_fill;
    host.wr(lcdd_pkg::REG_PTR, 8'h15);
    for (int k = 0; k < 23; k++) begin
      ram[(k + 21) % 22] = 8'(k * 29) ^ 8'hA5;
      host.wr(lcdd_pkg::REG_DATA, ram[(k + 21) % 22]);
    end
    rd_cmp(8'h15, ram[21]);
    rd_cmp(8'h00, ram[0]);
    rd_cmp(lcdd_pkg::REG_DATA, ram[0]);
    rd_cmp(lcdd_pkg::REG_PTR, 8'h00);
  endtask
  // Two frames of scanning show slot order and polarity flip
  task automatic t_scan;
    host.wr(lcdd_pkg::REG_SYSCTL, 8'h07);
    for (int k = 0; k < 8; k++) begin
      slot_cmp(k % 4, 1'((k / 4) % 2), 1'b0);
    end
    host.wr(lcdd_pkg::REG_MODE, 8'h01);
    repeat (2) @(posedge ref_clk_in);
    #1 cmp("bypass", 88'h1, {87'h0, byp});
    slot_cmp(1, 1'b0, 1'b1);
    host.wr(lcdd_pkg::REG_SYSCTL, 8'h03);
    repeat (3) @(posedge ref_clk_in);
    #1 cmp("commons off", {80'h0, 8'hFF}, {80'h0, com});
  endtask
  // Count cycles until the commons move on to another slot
  task automatic com_change(output int n);
    logic [7:0] prev;
    prev = com;
    n = 0;
    while (com === prev && n < 1000) begin
      @(posedge ref_clk_in);
      #1 n++;
    end
  endtask
  // Adjust fields reach their pins; fast frame halves the slot
  task automatic t_rate;
    int n;
    host.wr(lcdd_pkg::REG_VADJ, 8'h2A);
    @(posedge ref_clk_in);
    #1 cmp("adjust pins", 88'h1A, {82'h0, ven, vdet, vlvl});
    rd_cmp(lcdd_pkg::REG_VADJ, 8'h2A);
    host.wr(lcdd_pkg::REG_SYSCTL, 8'h07);
    host.wr(lcdd_pkg::REG_MODE, 8'h02);
    #1 cmp("osc bias on", 88'h3, {86'h0, osc, bias});
    com_change(n);
    com_change(n);
    cmp("fast slot cycles", 88'(FAST_SLOT), 88'(n));
  endtask
  // Blinking blanks every segment while commons keep scanning
  task automatic t_blink;
    int n;
    logic dark;
    host.wr(lcdd_pkg::REG_BLINK, 8'h03);
    rd_cmp(lcdd_pkg::REG_BLINK, 8'h03);
    host.wr(lcdd_pkg::REG_BLINK, 8'h01);
    n = 0;
    dark = 1'b0;
    while (!dark && n < 20000) begin
      @(posedge ref_clk_in);
      #1 n++;
      dark = (seg === {44{2'h2}}) || (seg === {44{2'h1}});
    end
    cmp("blanked segments", 88'h1, {87'h0, dark});
    cmp("commons scanning", 88'h1, {87'h0, com !== 8'hFF});
    host.wr(lcdd_pkg::REG_BLINK, 8'h00);
    com_change(n);
    dark = (seg === {44{2'h2}}) || (seg === {44{2'h1}});
    cmp("steady segments", 88'h0, {87'h0, dark});
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the wait for the first blank blink phase
  initial begin
    #400_000;
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 t_reset();
    t_fill();
    t_scan();
    t_rate();
    t_blink();
    end_sim();
  end
endmodule
`default_nettype wire
